//--- core/can_filter_buffer_pointer.sv
// Filter 4..11 receive destination pointers with APB register access
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "filter_dest_defines.svh"
module can_filter_buffer_pointer (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire filter_dest_pkg::filter_hit_type hit,
   output filter_dest_pkg::dest_select_type dest
);
   logic [15:0] filter_4_7_dest_pointer;
   logic [15:0] filter_8_11_dest_pointer;
   logic [15:0] next_filter_4_7_dest_pointer;
   logic [15:0] next_filter_8_11_dest_pointer;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic [3:0] last_filter;
   logic [3:0] next_last_filter;
   filter_dest_pkg::dest_select_type next_dest;
   logic [3:0] field [0:`DEST_FILTER_COUNT-1];
   logic setup;
   logic access;
   logic hit_in_range;
   logic [3:0] pick;
   logic [2:0] slot;

   // Field k holds filter k+4; both registers share one layout
   genvar g;
   generate
      for (g = 0; g < `DEST_FILTER_COUNT; g = g + 1) begin : g_field
         if (g < 4) begin : g_lo
            assign field[g] = filter_4_7_dest_pointer[g*4 +: 4];
         end else begin : g_hi
            assign field[g] = filter_8_11_dest_pointer[(g-4)*4 +: 4];
         end
      end
   endgenerate

   // Answer in the access cycle: pready is raised by the setup edge
   assign setup = psel && !penable && !pready;
   // Writes land only at the edge that ends the transfer, never in setup
   assign access = psel && penable && pready;

   always_comb begin
      next_filter_4_7_dest_pointer = filter_4_7_dest_pointer;
      next_filter_8_11_dest_pointer = filter_8_11_dest_pointer;
      next_prdata = 32'h00000000;
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      if (setup) begin
         next_pready = 1'b1;
         case (paddr)
            `FILTER_4_7_DEST_POINTER_ADDR: begin
               next_prdata = {16'h0000, filter_4_7_dest_pointer};
            end
            `FILTER_8_11_DEST_POINTER_ADDR: begin
               next_prdata = {16'h0000, filter_8_11_dest_pointer};
            end
            `DEST_STATUS_ADDR: begin
               next_prdata = {28'h0000000, last_filter};
               next_pslverr = pwrite;
            end
            default: begin
               next_pslverr = 1'b1;
            end
         endcase
      end
      if (access && pwrite) begin
         case (paddr)
            `FILTER_4_7_DEST_POINTER_ADDR: begin
               if (pstrb[0]) begin
                  next_filter_4_7_dest_pointer[7:0] = pwdata[7:0];
               end
               if (pstrb[1]) begin
                  next_filter_4_7_dest_pointer[15:8] = pwdata[15:8];
               end
            end
            `FILTER_8_11_DEST_POINTER_ADDR: begin
               if (pstrb[0]) begin
                  next_filter_8_11_dest_pointer[7:0] = pwdata[7:0];
               end
               if (pstrb[1]) begin
                  next_filter_8_11_dest_pointer[15:8] = pwdata[15:8];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Read data is taken at setup, so a write just before is already visible
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         filter_4_7_dest_pointer <= `DEST_POINTER_RESET;
         filter_8_11_dest_pointer <= `DEST_POINTER_RESET;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         filter_4_7_dest_pointer <= next_filter_4_7_dest_pointer;
         filter_8_11_dest_pointer <= next_filter_8_11_dest_pointer;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // Hits outside filters 4..11 belong to another block and are ignored
   assign hit_in_range = hit.valid && hit.filter_index >= `FIRST_FILTER
                         && hit.filter_index <= `LAST_FILTER;
   assign slot = 3'(hit.filter_index - `FIRST_FILTER);
   assign pick = field[slot];

   always_comb begin
      next_dest = '0;
      next_last_filter = last_filter;
      if (hit_in_range) begin
         next_dest.valid = 1'b1;
         next_dest.to_fifo = (pick == `DEST_FIFO_CODE);
         next_dest.buffer_index = (pick == `DEST_FIFO_CODE) ? 4'h0 : pick;
         next_last_filter = hit.filter_index;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         dest <= '0;
         last_filter <= 4'h0;
      end else begin
         dest <= next_dest;
         last_filter <= next_last_filter;
      end
   end

   // Register bus checks
   property p_reg_write;
      @(posedge sys_clk) disable iff (rst)
      (access && pwrite && paddr == `FILTER_4_7_DEST_POINTER_ADDR && pstrb == 4'hF)
      |=> (filter_4_7_dest_pointer == $past(pwdata[15:0]));
   endproperty
   a_reg_write: assert property (p_reg_write) else $error("low pointer write lost");

   property p_hi_write;
      @(posedge sys_clk) disable iff (rst)
      (access && pwrite && paddr == `FILTER_8_11_DEST_POINTER_ADDR && pstrb == 4'hF)
      |=> (filter_8_11_dest_pointer == $past(pwdata[15:0]));
   endproperty
   a_hi_write: assert property (p_hi_write) else $error("high pointer write lost");

   // Routing checks, one per filter slot
   property p_filter10;
      @(posedge sys_clk) disable iff (rst)
      (hit.valid && hit.filter_index == 4'hA && filter_8_11_dest_pointer[11:8] != 4'hF)
      |=> (dest.valid && dest.buffer_index == $past(filter_8_11_dest_pointer[11:8]));
   endproperty
   a_filter10: assert property (p_filter10) else $error("filter 10 misrouted");

   property p_filter9;
      @(posedge sys_clk) disable iff (rst)
      (hit.valid && hit.filter_index == 4'h9 && filter_8_11_dest_pointer[7:4] != 4'hF)
      |=> (dest.buffer_index == $past(filter_8_11_dest_pointer[7:4]) && !dest.to_fifo);
   endproperty
   a_filter9: assert property (p_filter9) else $error("filter 9 misrouted");

   property p_buffer;
      @(posedge sys_clk) disable iff (rst)
      (hit.valid && hit.filter_index == 4'h4 && filter_4_7_dest_pointer[3:0] != 4'hF)
      |=> (dest.valid && !dest.to_fifo
           && dest.buffer_index == $past(filter_4_7_dest_pointer[3:0]));
   endproperty
   a_buffer: assert property (p_buffer) else $error("buffer route wrong");

   property p_fifo;
      @(posedge sys_clk) disable iff (rst)
      (hit.valid && hit.filter_index == 4'h7 && filter_4_7_dest_pointer[15:12] == 4'hF)
      |=> dest.to_fifo;
   endproperty
   a_fifo: assert property (p_fifo) else $error("fifo route missed");

   property p_reset_zero;
      @(posedge sys_clk) $fell(rst)
      |-> (filter_4_7_dest_pointer == 16'h0000 && filter_8_11_dest_pointer == 16'h0000);
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("pointers not zero");

   sequence s_setup;
      setup;
   endsequence
   sequence s_access;
      pready ##1 !pready;
   endsequence
   property p_apb;
      @(posedge sys_clk) disable iff (rst)
      s_setup |=> s_access;
   endproperty
   a_apb: assert property (p_apb) else $error("apb answer timing wrong");

   property p_filter5;
      @(posedge sys_clk) disable iff (rst)
      (hit.valid && hit.filter_index == 4'h5 && filter_4_7_dest_pointer[7:4] != 4'hF)
      |=> (dest.valid && !dest.to_fifo
           && dest.buffer_index == $past(filter_4_7_dest_pointer[7:4]));
   endproperty
   a_filter5: assert property (p_filter5) else $error("filter 5 misrouted");

   property p_filter6;
      @(posedge sys_clk) disable iff (rst)
      (hit.valid && hit.filter_index == 4'h6 && filter_4_7_dest_pointer[11:8] != 4'hF)
      |=> (dest.valid && !dest.to_fifo
           && dest.buffer_index == $past(filter_4_7_dest_pointer[11:8]));
   endproperty
   a_filter6: assert property (p_filter6) else $error("filter 6 misrouted");

   property p_filter8;
      @(posedge sys_clk) disable iff (rst)
      (hit.valid && hit.filter_index == 4'h8 && filter_8_11_dest_pointer[3:0] != 4'hF)
      |=> (dest.valid && !dest.to_fifo
           && dest.buffer_index == $past(filter_8_11_dest_pointer[3:0]));
   endproperty
   a_filter8: assert property (p_filter8) else $error("filter 8 misrouted");

   property p_filter11;
      @(posedge sys_clk) disable iff (rst)
      (hit.valid && hit.filter_index == 4'hB && filter_8_11_dest_pointer[15:12] != 4'hF)
      |=> (dest.valid && !dest.to_fifo
           && dest.buffer_index == $past(filter_8_11_dest_pointer[15:12]));
   endproperty
   a_filter11: assert property (p_filter11) else $error("filter 11 misrouted");

   // FIFO route must not also name a buffer
   property p_fifo_hi;
      @(posedge sys_clk) disable iff (rst)
      (hit.valid && hit.filter_index == 4'h8 && filter_8_11_dest_pointer[3:0] == 4'hF)
      |=> (dest.valid && dest.to_fifo && dest.buffer_index == 4'h0);
   endproperty
   a_fifo_hi: assert property (p_fifo_hi) else $error("fifo route of filter 8 wrong");

   property p_low_ignored;
      @(posedge sys_clk) disable iff (rst)
      (hit.valid && hit.filter_index < 4'h4) |=> !dest.valid;
   endproperty
   a_low_ignored: assert property (p_low_ignored) else $error("foreign filter routed");

   property p_idle;
      @(posedge sys_clk) disable iff (rst)
      !hit.valid |=> !dest.valid;
   endproperty
   a_idle: assert property (p_idle) else $error("route without a hit");

   property p_last_filter;
      @(posedge sys_clk) disable iff (rst)
      (hit.valid && hit.filter_index >= 4'h4 && hit.filter_index <= 4'hB)
      |=> (last_filter == $past(hit.filter_index));
   endproperty
   a_last_filter: assert property (p_last_filter) else $error("last filter not kept");

   // Byte lanes are honoured, an absent lane keeps its old value
   property p_strobe_lane;
      @(posedge sys_clk) disable iff (rst)
      (access && pwrite && paddr == `FILTER_4_7_DEST_POINTER_ADDR && pstrb == 4'h1)
      |=> (filter_4_7_dest_pointer[15:8] == $past(filter_4_7_dest_pointer[15:8])
           && filter_4_7_dest_pointer[7:0] == $past(pwdata[7:0]));
   endproperty
   a_strobe_lane: assert property (p_strobe_lane) else $error("byte lane write wrong");

   property p_ptr_hold;
      @(posedge sys_clk) disable iff (rst)
      !(access && pwrite)
      |=> ($stable(filter_4_7_dest_pointer) && $stable(filter_8_11_dest_pointer));
   endproperty
   a_ptr_hold: assert property (p_ptr_hold) else $error("pointer changed without write");

   property p_read_lo;
      @(posedge sys_clk) disable iff (rst)
      (setup && !pwrite && paddr == `FILTER_4_7_DEST_POINTER_ADDR)
      |=> (pready && !pslverr && prdata == {16'h0000, $past(filter_4_7_dest_pointer)});
   endproperty
   a_read_lo: assert property (p_read_lo) else $error("low pointer read wrong");

   property p_read_hi;
      @(posedge sys_clk) disable iff (rst)
      (setup && !pwrite && paddr == `FILTER_8_11_DEST_POINTER_ADDR)
      |=> (pready && !pslverr && prdata == {16'h0000, $past(filter_8_11_dest_pointer)});
   endproperty
   a_read_hi: assert property (p_read_hi) else $error("high pointer read wrong");

   property p_status_ro;
      @(posedge sys_clk) disable iff (rst)
      (setup && pwrite && paddr == `DEST_STATUS_ADDR) |=> (pready && pslverr);
   endproperty
   a_status_ro: assert property (p_status_ro) else $error("status write not refused");

   property p_unmapped;
      @(posedge sys_clk) disable iff (rst)
      (setup && paddr != `FILTER_4_7_DEST_POINTER_ADDR
       && paddr != `FILTER_8_11_DEST_POINTER_ADDR && paddr != `DEST_STATUS_ADDR)
      |=> (pready && pslverr && prdata == 32'h00000000);
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access answered");
endmodule
`default_nettype wire

//--- core/filter_dest_defines.svh
// Register offsets, field positions and reset values of the filter destination block
`ifndef FILTER_DEST_DEFINES_SVH
`define FILTER_DEST_DEFINES_SVH
`define FILTER_4_7_DEST_POINTER_ADDR 12'h000
`define FILTER_8_11_DEST_POINTER_ADDR 12'h004
`define DEST_STATUS_ADDR 12'h008
`define DEST_POINTER_RESET 16'h0000
`define DEST_FIELD_WIDTH 4
`define DEST_FIFO_CODE 4'hF
`define FIRST_FILTER 4'h4
`define LAST_FILTER 4'hB
`define DEST_FILTER_COUNT 8
`endif

//--- core/filter_dest_pkg.sv
// Types shared by the filter destination block
package filter_dest_pkg;
   typedef struct packed {
      logic valid;
      logic [3:0] filter_index;
   } filter_hit_type;
   typedef struct packed {
      logic valid;
      logic to_fifo;
      logic [3:0] buffer_index;
   } dest_select_type;
endpackage

//--- bench/hit_source.sv
// Acceptance filter stand-in driving hit pulses
`timescale 1ns/10ps
`default_nettype none
module hit_source (
   input wire logic sys_clk,
   input wire logic go,
   input wire logic [3:0] idx,
   output filter_dest_pkg::filter_hit_type hit
);
   // Idle index keeps changing so a stale value is never trusted
   always_ff @(posedge sys_clk) begin
      hit.valid <= go;
      hit.filter_index <= go ? idx : ~hit.filter_index;
   end
endmodule
`default_nettype wire

//--- bench/can_filter_buffer_pointer_tb.sv
// Self-checking bench for the filter destination pointers
`timescale 1ns/10ps
`default_nettype none
module can_filter_buffer_pointer_tb;
   logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, go = 0, pready, pslverr, e;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r, got, d0, d1, seed = 32'hFCC41D7B;
   logic [3:0] pstrb = 4'hF, idx = 0;
   filter_dest_pkg::filter_hit_type hit;
   filter_dest_pkg::dest_select_type dest;
   int n_fail = 0, checks = 0, i, f;
   int ptr [4:11];
   can_filter_buffer_pointer dut_u (.sys_clk(sys_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .hit(hit), .dest(dest));
   hit_source src_u (.sys_clk(sys_clk), .go(go), .idx(idx), .hit(hit));
   initial forever #5 sys_clk = ~sys_clk;
   function logic [31:0] lfsr();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   function logic [31:0] want(int n);
      if (n < 4) return 32'h0;
      return {26'h0, 1'b1, ptr[n] == 15, ptr[n] == 15 ? 4'h0 : 4'(ptr[n])};
   endfunction
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task end_sim;
      if (n_fail == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge sys_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      for (k = 0; k < 20; k++) begin
         @(posedge sys_clk);
         if (pready === 1'b1) break;
      end
      if (k == 20) begin
         n_fail++;
         end_sim();
      end
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // Filter below 4 must give no destination at all
   task fire(input int n);
      int k;
      @(posedge sys_clk);
      go <= 1;
      idx <= 4'(n);
      @(posedge sys_clk);
      go <= 0;
      got = 32'h0;
      for (k = 0; k < 4; k++) begin
         @(posedge sys_clk);
         if (dest.valid === 1'b1) got = 32'(dest);
      end
   endtask
   initial begin
      repeat (6) @(posedge sys_clk);
      rst <= 0;
      apb(0, 12'h000, 0);
      check(r, 32'h0);
      apb(0, 12'h004, 0);
      check(r, 32'h0);
      for (i = 0; i < 2; i++) begin
         d0 = lfsr() | (32'h0000F000 >> (8 * i));
         d1 = lfsr() | (32'h0000000F << (8 * i));
         apb(1, 12'h000, d0);
         apb(1, 12'h004, d1);
         apb(0, 12'h000, 0);
         check(r, d0 & 32'h0000FFFF);
         apb(0, 12'h004, 0);
         check(r, d1 & 32'h0000FFFF);
         for (f = 4; f < 12; f++)
            ptr[f] = f < 8 ? (d0 >> (4 * (f - 4))) & 15 : (d1 >> (4 * (f - 8))) & 15;
         for (f = 3; f < 12; f++) begin
            fire(f);
            check(got, want(f));
         end
      end
      apb(0, 12'h008, 0);
      check(r, 32'h0000000B);
      apb(1, 12'h008, 32'h1);
      check(32'(e), 32'h1);
      apb(0, 12'h00C, 0);
      check({r[30:0], e}, 32'h1);
      // Only lane 0 enabled: the upper byte must survive
      pstrb <= 4'h1;
      apb(1, 12'h000, 32'h00005AC3);
      pstrb <= 4'hF;
      apb(0, 12'h000, 0);
      check(r, (d0 & 32'h0000FF00) | 32'h000000C3);
      // Reset in mid-run clears every pointer again
      rst <= 1;
      repeat (2) @(posedge sys_clk);
      rst <= 0;
      apb(0, 12'h000, 0);
      check(r, 32'h0);
      apb(0, 12'h004, 0);
      check(r, 32'h0);
      apb(0, 12'h008, 0);
      check(r, 32'h0);
      fire(4);
      check(got, 32'h00000020);
      end_sim();
   end
endmodule
`default_nettype wire
